// File: core/port23_defines.svh
// reset values and field codes for the port 2 / port 3 pin block
// assumes inclusion by bare name from core/ files
`ifndef PORT23_DEFINES_SVH
`define PORT23_DEFINES_SVH
`define P2_DIR_RST 8'hFF
`define P2_CFG_RST 4'h0
`define P2_CFG_ALL_DIGITAL 4'h1
`define P3_DIR_RST 2'h3
`define P3_PU_RST 2'h0
`define P3_BUF_RST 2'h0
`define P3_OD_RST 1'h0
`define P3_DATA_RST 2'h0
`define P2_DATA_RST 8'h00
`define REDIR_RJ_P31 2'h1
`define RJ_MODE_PULSE 3'h1
`endif

// File: core/port23_pkg.sv
// types shared by the port 2 / port 3 pin block
// assumes nothing beyond the defines header
package port23_pkg;
   typedef enum logic [1:0] {
      P31_GPIO = 2'h1,
      P31_ALT = 2'h2
   } p31_src_t;
endpackage

// File: core/sync2.sv
// two-flop synchroniser for a bus of pin levels
// assumes pins are asynchronous to sys_clk_i
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_ff;
   // first stage read only by the second
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         q_o <= '0;
      end else begin
         meta_ff <= d_i;
         q_o <= meta_ff;
      end
   end
endmodule

// File: core/port23_pins.sv
// pin control for the eight-pin analog-shared port and the two-pin port
// assumes control registers are written over plain strobes on sys_clk_i
// How it works
// - port2 direction per pin from its bit
// - config 01..n+1 makes pin n upward digital
// - analog pins fill from lowest pin upward
// - analog input feeds converter when channel selected
// - reset puts all port2 pins analog input
// - port3 direction per pin from its bit
// - reset puts port3 pins in input mode
// - pull-up on input pins when selected
// - buffer select 0 CMOS, 1 TTL
// - pin0 output 0 push-pull, 1 open-drain
// - redirected alternates only when redirection selects
`timescale 1ns/1ps
`include "port23_defines.svh"
module port23_pins #(
   parameter int P2_WIDTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // software write strobes and data
   input wire logic p2_dir_we_i,
   input wire logic p2_cfg_we_i,
   input wire logic p2_data_we_i,
   input wire logic p3_dir_we_i,
   input wire logic p3_pu_we_i,
   input wire logic p3_buf_we_i,
   input wire logic p3_od_we_i,
   input wire logic p3_data_we_i,
   input wire logic [7:0] wdata_i,
   // channel selection and peripheral outputs
   input wire logic [2:0] converter_channel_select_i,
   input wire logic serial_clock_out_i,
   input wire logic serial_clock_en_i,
   input wire logic rj_timer_output_i,
   input wire logic rj_output_enable_i,
   input wire logic tau_channel3_output_i,
   input wire logic tau_channel3_en_i,
   input wire logic clock_buzzer_out_i,
   input wire logic clock_buzzer_out_enable_i,
   input wire logic rj_timer_io_out_i,
   input wire logic rj_timer_io_en_i,
   input wire logic [1:0] io_redirection_i,
   // pins
   input wire logic [7:0] port2_pin_i,
   output logic [7:0] port2_pin_o,
   output logic [7:0] port2_pin_oe_o,
   output logic [7:0] port2_analog_o,
   output logic [7:0] port2_convert_o,
   input wire logic [1:0] port3_pin_i,
   output logic [1:0] port3_pin_o,
   output logic [1:0] port3_pin_oe_o,
   output logic [1:0] port3_pullup_o,
   output logic [1:0] port3_ttl_o,
   // readback
   output logic [7:0] port2_rdata_o,
   output logic [1:0] port3_rdata_o,
   output logic [7:0] port2_direction_o,
   output logic [3:0] port2_config_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] port2_direction_reg_ff;
   logic [3:0] analog_digital_pin_config_ff;
   logic [7:0] p2_latch_ff;
   logic [1:0] port3_direction_reg_ff;
   logic [1:0] port3_pullup_select_ff;
   logic [1:0] port3_input_buffer_select_ff;
   logic port3_open_drain_select_ff;
   logic [1:0] p3_latch_ff;
   logic [7:0] p2_sync;
   logic [1:0] p3_sync;
   logic [7:0] digital_mask;
   logic [7:0] p2_rd_ff;
   logic [1:0] p3_rd_ff;
   port23_pkg::p31_src_t p31_src;

   // digital mask: value v in 1..8 makes pins v-1..7 digital, 0 and >8 analog
   function automatic logic [7:0] cfg_mask(input logic [3:0] cfg);
      logic [7:0] m;
      m = 8'h00;
      if (cfg >= `P2_CFG_ALL_DIGITAL && cfg <= 4'h8) begin
         m = 8'hFF << (cfg - 4'h1);
      end
      return m;
   endfunction

   assign digital_mask = cfg_mask(analog_digital_pin_config_ff);

   sync2 #(.WIDTH(8)) u_sync_p2 (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .d_i(port2_pin_i),
      .q_o(p2_sync)
   );
   sync2 #(.WIDTH(2)) u_sync_p3 (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .d_i(port3_pin_i),
      .q_o(p3_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // port 2 control registers, all analog input after reset
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         port2_direction_reg_ff <= `P2_DIR_RST;
         analog_digital_pin_config_ff <= `P2_CFG_RST;
      end else begin
         if (p2_dir_we_i) begin
            port2_direction_reg_ff <= wdata_i;
         end
         if (p2_cfg_we_i) begin
            analog_digital_pin_config_ff <= wdata_i[3:0];
         end
      end
   end

   // output latches take writes in any direction
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p2_latch_ff <= `P2_DATA_RST;
         p3_latch_ff <= `P3_DATA_RST;
      end else begin
         if (p2_data_we_i) begin
            p2_latch_ff <= wdata_i;
         end
         if (p3_data_we_i) begin
            p3_latch_ff <= wdata_i[1:0];
         end
      end
   end

   // port 3 control registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         port3_direction_reg_ff <= `P3_DIR_RST;
         port3_pullup_select_ff <= `P3_PU_RST;
         port3_input_buffer_select_ff <= `P3_BUF_RST;
         port3_open_drain_select_ff <= `P3_OD_RST;
      end else begin
         if (p3_dir_we_i) begin
            port3_direction_reg_ff <= wdata_i[1:0];
         end
         if (p3_pu_we_i) begin
            port3_pullup_select_ff <= wdata_i[1:0];
         end
         if (p3_buf_we_i) begin
            port3_input_buffer_select_ff <= wdata_i[1:0];
         end
         if (p3_od_we_i) begin
            port3_open_drain_select_ff <= wdata_i[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // port 2 pin drive; analog pins never drive even if software errs
   always_comb begin
      port2_pin_o = p2_latch_ff;
      port2_pin_oe_o = ~port2_direction_reg_ff & digital_mask;
      port2_analog_o = ~digital_mask & port2_direction_reg_ff;
      port2_convert_o = 8'h00;
      if (P2_WIDTH > 0) begin
         port2_convert_o[converter_channel_select_i] =
            port2_analog_o[converter_channel_select_i];
      end
   end

   // pin1 source: redirected rj timer only when redirection picks it
   always_comb begin
      if (io_redirection_i == `REDIR_RJ_P31 && rj_timer_io_en_i) begin
         p31_src = port23_pkg::P31_ALT;
      end else begin
         p31_src = port23_pkg::P31_GPIO;
      end
   end

   // port 3 drive; alternates AND into the latch, so defaults keep gpio clean
   logic p30_val;
   logic p31_val;
   always_comb begin
      p30_val = p3_latch_ff[0];
      if (serial_clock_en_i) begin
         p30_val = p30_val & serial_clock_out_i;
      end
      if (rj_output_enable_i) begin
         p30_val = p30_val & rj_timer_output_i;
      end
      p31_val = p3_latch_ff[1];
      if (tau_channel3_en_i) begin
         p31_val = p31_val & tau_channel3_output_i;
      end
      if (clock_buzzer_out_enable_i) begin
         p31_val = p31_val & clock_buzzer_out_i;
      end
      if (p31_src == port23_pkg::P31_ALT) begin
         p31_val = p31_val & rj_timer_io_out_i;
      end
   end

   // pin0 open-drain: drive only low, release high to the pull of the board; pin1 stays push-pull
   always_comb begin
      port3_pin_o = {p31_val, p30_val};
      port3_pin_oe_o[1] = ~port3_direction_reg_ff[1];
      if (port3_open_drain_select_ff) begin
         port3_pin_o[0] = 1'h0;
         port3_pin_oe_o[0] = ~port3_direction_reg_ff[0] & ~p30_val;
      end else begin
         port3_pin_oe_o[0] = ~port3_direction_reg_ff[0];
      end
      port3_pullup_o = port3_pullup_select_ff & port3_direction_reg_ff;
      port3_ttl_o = port3_input_buffer_select_ff;
   end

   ////////////////////////////////////////////////////////////////////////
   // readback registered; analog pins read as zero
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p2_rd_ff <= 8'h00;
         p3_rd_ff <= 2'h0;
      end else begin
         p2_rd_ff <= ((p2_sync & port2_direction_reg_ff)
                     | (p2_latch_ff & ~port2_direction_reg_ff)) & digital_mask;
         p3_rd_ff <= (p3_sync & port3_direction_reg_ff)
                     | (p3_latch_ff & ~port3_direction_reg_ff);
      end
   end

   assign port2_rdata_o = p2_rd_ff;
   assign port3_rdata_o = p3_rd_ff;
   assign port2_direction_o = port2_direction_reg_ff;
   assign port2_config_o = analog_digital_pin_config_ff;

   ////////////////////////////////////////////////////////////////////////
   // a write strobe shows as the register value one cycle later
   sequence s_dir_written;
      p2_dir_we_i ##1 1'h1;
   endsequence
   sequence s_latch_written;
      p2_data_we_i ##1 1'h1;
   endsequence

   a_p2_dir_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_dir_written |-> port2_direction_reg_ff == $past(wdata_i))
      else $error("port2 direction not loaded");
   a_p3_dir_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      p3_dir_we_i |=> port3_direction_reg_ff == $past(wdata_i[1:0]))
      else $error("port3 direction not loaded");
   a_p3_oe_dir: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      port3_pin_oe_o[1] == !port3_direction_reg_ff[1])
      else $error("port3 pin1 enable against direction");
   a_analog_no_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (port2_pin_oe_o & ~digital_mask) == 8'h00)
      else $error("analog pin driven");
   a_cfg_one_all: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      analog_digital_pin_config_ff == 4'h1 |-> digital_mask == 8'hFF)
      else $error("config 1 not all digital");
   a_convert_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      port2_convert_o != 8'h00 |-> port2_analog_o[converter_channel_select_i])
      else $error("convert of unselected pin");
   a_pullup_input: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (port3_pullup_o & ~port3_direction_reg_ff) == 2'h0)
      else $error("pull-up on output pin");
   a_od_no_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      port3_open_drain_select_ff && port3_pin_oe_o[0] |-> !port3_pin_o[0])
      else $error("open-drain drove high");
   a_latch_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_latch_written |-> p2_latch_ff == $past(wdata_i))
      else $error("latch not updated");
   a_read_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      port3_direction_reg_ff == 2'h0 && $stable(p3_latch_ff)
      |=> port3_rdata_o == $past(p3_latch_ff))
      else $error("output pin read not latch");
   // analog pins never leak pin levels into readback
   a_p2_read_mask: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      1'h1 |=> (port2_rdata_o & ~$past(digital_mask)) == 8'h00)
      else $error("analog pin read not zero");
   a_ttl_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      port3_ttl_o == port3_input_buffer_select_ff ##1
      $past(p3_buf_we_i) |-> port3_ttl_o == $past(wdata_i[1:0]))
      else $error("buffer select wrong");

   // reset leaves port 2 analog input and port 3 input
   a_reset_analog: assert property (@(posedge sys_clk_i)
      $fell(rst_i) |-> port2_direction_reg_ff == `P2_DIR_RST
      && analog_digital_pin_config_ff == `P2_CFG_RST)
      else $error("port2 not analog input after reset");
   a_reset_input: assert property (@(posedge sys_clk_i)
      $fell(rst_i) |-> port3_direction_reg_ff == `P3_DIR_RST)
      else $error("port3 not input after reset");
   // timer io reaches pin1 only under the redirection code
   a_redirect_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      io_redirection_i != `REDIR_RJ_P31 |-> p31_src == port23_pkg::P31_GPIO)
      else $error("timer io routed without redirection");
endmodule

// File: test/pin_model.sv
// far-side pin model: external drivers, pull-ups and floating lines
// assumes the bench says which pins it drives from outside
`timescale 1ns/1ps
module pin_model #(
   parameter int W = 8
) (
   input wire logic [W-1:0] pin_o_i,
   input wire logic [W-1:0] oe_i,
   input wire logic [W-1:0] pullup_i,
   input wire logic [W-1:0] ext_i,
   input wire logic [W-1:0] ext_en_i,
   output logic [W-1:0] level_o
);
   ////////////////////////////////////////////////////////////////
   // released lines with no outside driver or pull-up show the inverse of pin_o_i, so a stale value never reads as valid
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (oe_i[i]) begin
            level_o[i] = pin_o_i[i];
         end else if (ext_en_i[i]) begin
            level_o[i] = ext_i[i];
         end else if (pullup_i[i]) begin
            level_o[i] = 1'b1;
         end else begin
            level_o[i] = ~pin_o_i[i];
         end
      end
   end
endmodule

// File: test/tb.sv
// self-checking bench for port23_pins with random register traffic
// assumes the design and pin_model are compiled first
`timescale 1ns/1ps
module tb;
   logic sys_clk_i = 0, rst_i = 1;
   logic [7:0] we = 8'h00, wdata = 8'h00, ext2 = 8'h00, en2 = 8'h00;
   logic [2:0] sel = 3'h0;
   logic [4:0] alt_en = 5'h00, alt_val = 5'h00;
   logic [1:0] redir = 2'h0, ext3 = 2'h0, en3 = 2'h0;
   logic [7:0] p2i, p2o, p2oe, p2an, p2cv, p2rd, p2dir;
   logic [3:0] p2cfg;
   logic [1:0] p3i, p3o, p3oe, p3pu, p3ttl, p3rd;
   int miscompares = 0, comparisons = 0, seed = 32'h5c44;
   logic [7:0] cfg, dir, lat, m;
   logic [1:0] d3, pu, bf, l3;
   ////////////////////////////////////////////////////////////////
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   port23_pins uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .p2_dir_we_i(we[0]),
      .p2_cfg_we_i(we[1]), .p2_data_we_i(we[2]), .p3_dir_we_i(we[3]), .p3_pu_we_i(we[4]),
      .p3_buf_we_i(we[5]), .p3_od_we_i(we[6]), .p3_data_we_i(we[7]), .wdata_i(wdata),
      .converter_channel_select_i(sel), .serial_clock_out_i(alt_val[0]),
      .serial_clock_en_i(alt_en[0]), .rj_timer_output_i(alt_val[1]),
      .rj_output_enable_i(alt_en[1]), .tau_channel3_output_i(alt_val[2]),
      .tau_channel3_en_i(alt_en[2]), .clock_buzzer_out_i(alt_val[3]),
      .clock_buzzer_out_enable_i(alt_en[3]), .rj_timer_io_out_i(alt_val[4]),
      .rj_timer_io_en_i(alt_en[4]), .io_redirection_i(redir), .port2_pin_i(p2i),
      .port2_pin_o(p2o), .port2_pin_oe_o(p2oe), .port2_analog_o(p2an),
      .port2_convert_o(p2cv), .port3_pin_i(p3i), .port3_pin_o(p3o), .port3_pin_oe_o(p3oe),
      .port3_pullup_o(p3pu), .port3_ttl_o(p3ttl), .port2_rdata_o(p2rd),
      .port3_rdata_o(p3rd), .port2_direction_o(p2dir), .port2_config_o(p2cfg));
   pin_model #(.W(8)) far2 (.pin_o_i(p2o), .oe_i(p2oe),
      .pullup_i(8'h00), .ext_i(ext2), .ext_en_i(en2), .level_o(p2i));
   pin_model #(.W(2)) far3 (.pin_o_i(p3o), .oe_i(p3oe),
      .pullup_i(p3pu), .ext_i(ext3), .ext_en_i(en3), .level_o(p3i));
   ////////////////////////////////////////////////////////////////
   // digital pins count down from the top pin
   function automatic logic [7:0] dmask(input logic [7:0] v);
      return (v >= 8'h01 && v <= 8'h08) ? (8'hFF << (v - 8'h01)) : 8'h00;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one-hot strobe held over the taking edge; the caller drops it after a run
   task automatic wr(input int k, input logic [7:0] d);
      we = 8'h01 << k;
      wdata = d;
      @(posedge sys_clk_i) #1;
   endtask
   task automatic final_report();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // watchdog: the whole run is about 500 cycles
   initial begin
      #200000;
      miscompares++;
      final_report();
   end
   initial begin
      repeat (10) @(posedge sys_clk_i);
      #1 rst_i = 1'h0;
      check(p2dir, 8'hFF);
      check(p2an, 8'hFF);
      check(p2oe, 8'h00);
      check({p3oe, p3pu}, 4'h0);
      // first 16 passes sweep every config code, then random
      for (int i = 0; i < 40; i++) begin
         cfg = (i < 16) ? i[7:0] : {4'h0, 4'($random(seed))};
         m = dmask(cfg);
         dir = 8'($random(seed)) | ~m;
         lat = 8'($random(seed));
         d3 = 2'($random(seed));
         pu = 2'($random(seed));
         bf = 2'($random(seed));
         l3 = 2'($random(seed));
         ext2 = 8'($random(seed));
         ext3 = 2'($random(seed));
         sel = 3'($random(seed));
         en2 = dir;
         en3 = d3;
         wr(1, cfg);
         wr(2, lat);
         wr(0, dir);
         wr(3, {6'h00, d3});
         wr(4, {6'h00, pu});
         wr(5, {6'h00, bf});
         wr(6, {7'h00, i[0]});
         wr(7, {6'h00, l3});
         we = 8'h00;
         repeat (4) @(posedge sys_clk_i) #1;
         check(p2oe, ~dir & m);
         check(p2an, ~m & dir);
         check(p2cv, ~m & dir & (8'h01 << sel));
         check(p2o, lat);
         check(p2i & ~dir, lat & ~dir);
         check(p2rd, m & ((dir & ext2) | (~dir & lat)));
         check(p3pu, pu & d3);
         check(p3ttl, bf);
         check(p3oe, ~d3 & {1'h1, ~(i[0] & l3[0])});
         check(p3rd, (d3 & ext3) | (~d3 & l3));
      end
      // alternates off by default keep gpio; each one pulls its pin low, timer io only when redirected
      wr(3, 8'h00);
      wr(6, 8'h00);
      wr(7, 8'h03);
      we = 8'h00;
      alt_val = 5'h00;
      for (int k = 0; k < 6; k++) begin
         alt_en = (k < 5) ? (5'h01 << k) : 5'h10;
         redir = (k == 4) ? 2'h1 : 2'h0;
         @(posedge sys_clk_i) #1;
         check(p3o, (k < 2) ? 2'h2 : (k < 5) ? 2'h1 : 2'h3);
      end
      alt_en = 5'h00;
      final_report();
   end
endmodule
